//--- shared/usg_pkg.sv
// Shared constants and types for the unattended start guard.
// Assumes a single 20 MHz control clock and pins that are asynchronous to it.
package usg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  // Least time the inputs are watched after power-up before deciding
  localparam int POWERUP_SETTLE_NS = 1000;
  localparam int POWERUP_SETTLE_CYCLES = (POWERUP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Error codes shown on the display path
  // ----------------------------------------------------------------
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_UNDERVOLT = 8'h09;
  localparam logic [7:0] ERR_EXT_TRIP = 8'h0c;
  localparam logic [7:0] ERR_START_GUARD = 8'h0d;

  // ----------------------------------------------------------------
  // Pin group and status group
  // ----------------------------------------------------------------
  typedef struct packed {
    logic run_cmd;
    logic start_guard_input;
    logic trip_clear_terminal;
    logic keypad_stop_reset;
    logic external_trip_input;
    logic undervoltage_input;
  } usg_pins_t;

  localparam int PIN_COUNT = $bits(usg_pins_t);
  localparam usg_pins_t PINS_IDLE = '0;

  typedef struct packed {
    logic drive_on;
    logic alarm;
    logic trip_event;
    logic [7:0] err_code;
  } usg_status_t;

  localparam usg_status_t STATUS_RESET = '0;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_STOP = 3'b001,
    ST_RUN = 3'b010,
    ST_GUARD_TRIP = 3'b011,
    ST_EXT_TRIP = 3'b100,
    ST_UV_TRIP = 3'b101
  } usg_state_t;

endpackage : usg_pkg

//--- rtl/usg_sync.sv
// Two-flop synchroniser for the guard's pin group.
// Assumes every bit is an independent level from outside the clock domain.
`timescale 1ns/1ns
module usg_sync #(
  parameter int WIDTH = usg_pkg::PIN_COUNT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import usg_pkg::*;

  logic [WIDTH-1:0] meta;

  // ----------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------
  // Bits cross independently; the guard only looks at single-bit levels and edges
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        meta[i] <= 1'b0;
        sync_out[i] <= 1'b0;
      end
      else
      begin
        meta[i] <= async_in[i];
        sync_out[i] <= meta[i];
      end
    end
  end

endmodule : usg_sync

//--- rtl/usg_guard.sv
// Unattended start guard: decides whether the drive output may run after
// power-up, and latches the start-guard, external and undervoltage trips.
// Assumes reset_n is the power-up reset and all pins are asynchronous.
//
// Summary of operation
// [RULE_01] Guard off, run at power-up: run
// [RULE_02] Guard on, run at power-up: trip E13
// [RULE_03] Outside clears trip: run off or reset
// [RULE_04] After run-off clear, fresh run starts
// [RULE_05] Terminal reset with run held: resume
// [RULE_06] Guard still applies after E09 clear
// [RULE_07] Guard input blocks power-up resume
// [RULE_08] Guard off: power-up resumes active run
// [RULE_09] Guarded external trip clear: no restart
// [RULE_10] Guard trip latched until cleared
`timescale 1ns/1ns
module usg_guard #(
  parameter int SETTLE_CYCLES = usg_pkg::POWERUP_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire usg_pkg::usg_pins_t pins,
  output usg_pkg::usg_status_t status,
  output usg_pkg::usg_state_t state
);
  import usg_pkg::*;

  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  usg_pins_t pins_s;
  usg_pins_t pins_d;
  logic [PIN_COUNT-1:0] pins_s_vec;

  usg_sync #(
    .WIDTH(PIN_COUNT)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(pins),
    .sync_out(pins_s_vec)
  );

  assign pins_s = usg_pins_t'(pins_s_vec);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pins_d <= PINS_IDLE;
    end
    else
    begin
      pins_d <= pins_s;
    end
  end

  wire run_level = pins_s.run_cmd;
  wire guard_level = pins_s.start_guard_input;
  wire run_rise = pins_s.run_cmd & ~pins_d.run_cmd;
  wire run_fall = ~pins_s.run_cmd & pins_d.run_cmd;
  // Terminal reset acts on release, so the output stays off while it is held
  wire term_release = ~pins_s.trip_clear_terminal & pins_d.trip_clear_terminal;
  wire term_held = pins_s.trip_clear_terminal;
  wire key_press = pins_s.keypad_stop_reset & ~pins_d.keypad_stop_reset;
  wire ext_rise = pins_s.external_trip_input & ~pins_d.external_trip_input;
  wire uv_rise = pins_s.undervoltage_input & ~pins_d.undervoltage_input;
  wire manual_reset = term_release | key_press;

  // ----------------------------------------------------------------
  // Power-up settle counter
  // ----------------------------------------------------------------
  // Waits past the synchroniser so the run level seen is the real one
  logic [CNT_W-1:0] settle_cnt;
  logic [CNT_W-1:0] next_settle_cnt;
  wire settle_done = (settle_cnt == SETTLE_LAST);

  assign next_settle_cnt = (state == ST_POWERUP && !settle_done) ? settle_cnt + CNT_ONE
                                                                  : settle_cnt;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      settle_cnt <= CNT_ZERO;
    end
    else
    begin
      settle_cnt <= next_settle_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Power-up and post-undervoltage decision
  // ----------------------------------------------------------------
  // [RULE_07] Guard blocks resume
  // [RULE_02] Guarded run trips
  // [RULE_01] Unguarded run starts
  // [RULE_08] Active run resumes
  usg_state_t resume_state;
  assign resume_state = !run_level ? ST_STOP :
                        guard_level ? ST_GUARD_TRIP : ST_RUN;

  // [RULE_05] Resume when run held
  usg_state_t cleared_state;
  assign cleared_state = run_level ? ST_RUN : ST_STOP;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  usg_state_t next_state;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_POWERUP:
      begin
        if (settle_done)
        begin
          next_state = resume_state;
        end
      end
      ST_STOP:
      begin
        if (uv_rise)
        begin
          next_state = ST_UV_TRIP;
        end
        else if (ext_rise)
        begin
          next_state = ST_EXT_TRIP;
        end
        // [RULE_04] Fresh run starts
        else if (run_rise && !term_held)
        begin
          next_state = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (uv_rise)
        begin
          next_state = ST_UV_TRIP;
        end
        else if (ext_rise)
        begin
          next_state = ST_EXT_TRIP;
        end
        else if (!run_level)
        begin
          next_state = ST_STOP;
        end
      end
      ST_GUARD_TRIP:
      begin
        // [RULE_10] Latched until cleared
        // [RULE_03] Run off clears
        if (run_fall || !run_level)
        begin
          next_state = ST_STOP;
        end
        // [RULE_03] Reset clears
        else if (manual_reset)
        begin
          next_state = cleared_state;
        end
      end
      ST_EXT_TRIP:
      begin
        if (manual_reset)
        begin
          // [RULE_09] Guarded clear waits
          next_state = guard_level ? ST_STOP : cleared_state;
        end
      end
      ST_UV_TRIP:
      begin
        // [RULE_06] Guard rechecked
        if (manual_reset)
        begin
          next_state = resume_state;
        end
      end
      default:
      begin
        next_state = ST_POWERUP;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ST_POWERUP;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  wire next_is_trip = (next_state == ST_GUARD_TRIP) || (next_state == ST_EXT_TRIP) ||
                      (next_state == ST_UV_TRIP);
  wire now_is_trip = (state == ST_GUARD_TRIP) || (state == ST_EXT_TRIP) ||
                     (state == ST_UV_TRIP);

  logic [7:0] next_err_code;
  assign next_err_code = (next_state == ST_GUARD_TRIP) ? ERR_START_GUARD :
                         (next_state == ST_EXT_TRIP) ? ERR_EXT_TRIP :
                         (next_state == ST_UV_TRIP) ? ERR_UNDERVOLT : ERR_NONE;

  usg_status_t next_status;
  // Holding the reset terminal keeps the bridge off even in the run state
  assign next_status = '{drive_on: (next_state == ST_RUN) && !term_held,
                         alarm: next_is_trip,
                         trip_event: next_is_trip && !now_is_trip,
                         err_code: next_err_code};

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status <= STATUS_RESET;
    end
    else
    begin
      status <= next_status;
    end
  end

endmodule : usg_guard

//--- tb/usg_guard_asserts.sv
// Checker for the unattended start guard.
// Assumes pins reach the logic through two sync flops and one register.
`timescale 1ns/1ns
module usg_guard_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire usg_pkg::usg_pins_t pins,
  input wire usg_pkg::usg_status_t status,
  input wire usg_pkg::usg_state_t state
);
  import usg_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Cycles with run held and no clearing action; sync delay needs three
  logic [2:0] quiet;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      quiet <= 3'h0;
    else if (!pins.run_cmd || pins.trip_clear_terminal || pins.keypad_stop_reset)
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;
  a_guard_trip_off: assert property (
    state == ST_GUARD_TRIP |-> status.alarm && !status.drive_on
      && status.err_code == ERR_START_GUARD) else $error("guard trip outputs wrong");
  a_guard_latched: assert property (
    state == ST_GUARD_TRIP && quiet >= 3'h5 |=> state == ST_GUARD_TRIP)
    else $error("guard trip left without clearing");
  // Two low samples of the run pin reach the sequencer two edges later
  a_run_clears_guard: assert property (
    (!pins.run_cmd [*2] ##0 state == ST_GUARD_TRIP)
      |-> ##2 (state == ST_STOP && !status.alarm))
    else $error("run off did not clear guard trip");
  a_fresh_run_starts: assert property (
    (!pins.run_cmd ##1 pins.run_cmd && state == ST_STOP && !pins.trip_clear_terminal
      && !pins.undervoltage_input && !pins.external_trip_input) |-> ##[1:4] state == ST_RUN)
    else $error("fresh run did not start");
  a_trip_pulse_once: assert property (
    $rose(status.alarm) |-> status.trip_event ##1 !status.trip_event)
    else $error("trip event pulse wrong");
  a_terminal_holds_off: assert property (
    pins.trip_clear_terminal [*4] |-> !status.drive_on) else $error("drive on under reset");
  a_ext_trip_off: assert property (
    state == ST_EXT_TRIP |-> !status.drive_on && status.err_code == ERR_EXT_TRIP)
    else $error("external trip outputs wrong");
  a_uv_trip_code: assert property (
    state == ST_UV_TRIP |-> !status.drive_on && status.err_code == ERR_UNDERVOLT)
    else $error("undervoltage trip outputs wrong");
  c_guard: cover property (state == ST_GUARD_TRIP);
  c_ext: cover property (state == ST_EXT_TRIP);
  c_uv: cover property (state == ST_UV_TRIP);
endmodule : usg_guard_asserts

bind usg_guard usg_guard_asserts chk (.clk(clk), .reset_n(reset_n), .pins(pins),
  .status(status), .state(state));

//--- tb/usg_panel.sv
// Model of the run command, reset terminal, keypad and trip inputs.
// Assumes the bench calls its tasks; every change lands 1 ns after a rising edge.
`timescale 1ns/1ns
module usg_panel (
  input wire logic clk,
  output usg_pkg::usg_pins_t pins
);
  import usg_pkg::*;
  initial pins = PINS_IDLE;
  task automatic set(input int idx, input logic v);
    @(posedge clk);
    #1 pins[idx] = v;
  endtask : set
  task automatic pulse(input int idx);
    set(idx, 1'b1);
    repeat (4) @(posedge clk);
    set(idx, 1'b0);
  endtask : pulse
endmodule : usg_panel

//--- tb/unattended_start_guard_test.sv
// Self-checking bench for the unattended start guard.
// Assumes the panel model drives the pins and a shortened settle count.
`timescale 1ns/1ns
module unattended_start_guard_test;
  import usg_pkg::*;
  localparam int SC = 4;
  localparam int RUN = 5, GRD = 4, CLR = 3, KEY = 2, EXTERNAL_TRIP_INPUT = 1, UV = 0;
  localparam logic [11:0] X_RUN = {ST_RUN, 1'b1, ERR_NONE};
  localparam logic [11:0] X_STOP = {ST_STOP, 1'b0, ERR_NONE};
  localparam logic [11:0] X_GRD = {ST_GUARD_TRIP, 1'b0, ERR_START_GUARD};
  localparam logic [13:0] ROWS [4] = '{{2'b00, X_STOP}, {2'b01, X_RUN},
    {2'b10, X_STOP}, {2'b11, X_GRD}};
  logic clk;
  logic reset_n = 1'b0;
  usg_pins_t pins;
  usg_status_t stat;
  usg_state_t st;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  usg_panel panel (.clk(clk), .pins(pins));
  usg_guard #(.SETTLE_CYCLES(SC)) DUT (.clk(clk), .reset_n(reset_n), .pins(pins),
    .status(stat), .state(st));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      results();
    end
  end
  // Alarm is expected exactly when an error code is shown
  task automatic look(input int n, input logic [11:0] exp);
    logic [12:0] seen;
    logic [12:0] want;
    repeat (n) @(posedge clk);
    #2 samples_checked++;
    seen = {st, stat.drive_on, stat.alarm, stat.err_code};
    want = {exp[11:8], exp[7:0] != ERR_NONE, exp[7:0]};
    if (seen !== want)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : look
  task automatic power_up(input logic g, input logic r);
    @(posedge clk);
    #1 reset_n = 1'b0;
    for (int b = 0; b < 6; b++)
      panel.set(b, b == GRD ? g : (b == RUN ? r : 1'b0));
    repeat (5) @(posedge clk);
    #1 reset_n = 1'b1;
  endtask : power_up
  initial
  begin
    foreach (ROWS[i])
    begin
      power_up(ROWS[i][13], ROWS[i][12]);
      look(SC + 6, ROWS[i][11:0]);
    end
    power_up(1'b1, 1'b1);
    // The guard must be seen at the decision before it is dropped
    look(SC + 6, X_GRD);
    panel.set(GRD, 1'b0);
    look(8, X_GRD);
    panel.set(RUN, 1'b0);
    look(5, X_STOP);
    panel.set(RUN, 1'b1);
    look(5, X_RUN);
    for (int k = 0; k < 2; k++)
    begin
      power_up(1'b1, 1'b1);
      look(SC + 6, X_GRD);
      panel.pulse(k ? KEY : CLR);
      look(5, X_RUN);
    end
    panel.set(EXTERNAL_TRIP_INPUT, 1'b1);
    look(5, {ST_EXT_TRIP, 1'b0, ERR_EXT_TRIP});
    panel.set(EXTERNAL_TRIP_INPUT, 1'b0);
    panel.pulse(CLR);
    look(6, X_STOP);
    panel.set(RUN, 1'b0);
    panel.set(RUN, 1'b1);
    look(5, X_RUN);
    panel.set(UV, 1'b1);
    look(5, {ST_UV_TRIP, 1'b0, ERR_UNDERVOLT});
    panel.pulse(CLR);
    look(6, X_GRD);
    results();
  end
endmodule : unattended_start_guard_test
